//--- src/bas_pkg.sv
// Package for the station address source selector
package bas_pkg;
    localparam int ADDR_W = 7;
    localparam int SW_W   = 8;
    localparam logic [ADDR_W-1:0] ADDR_MIN = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7E;
    localparam logic [ADDR_W-1:0] CFG_RESET = 7'h7E;
    localparam int SRC_BIT = 7;

    typedef enum logic [2:0] {
        BAS_IDLE   = 3'b001,
        BAS_SAMPLE = 3'b010,
        BAS_RUN    = 3'b100
    } bas_state_type;

    typedef struct packed {
        logic              valid;
        logic              from_switch;
        logic              bad_switch;
        logic [ADDR_W-1:0] addr;
    } bas_addr_type;
endpackage : bas_pkg

//--- src/bas_select.sv
// Station address source selector, latched once after reset
// Summary of operation
// - Switch addresses valid only from 3 to 126
// - Positions one to seven are bits 0-6
// - Position ON reads as one, OFF zero
// - Eighth position OFF selects configured address
// - New address takes effect only after reset
module bas_select (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic [bas_pkg::SW_W-1:0]   switch_on,
    input  wire logic                       cfg_we,
    input  wire logic [bas_pkg::ADDR_W-1:0] cfg_addr,
    output bas_pkg::bas_addr_type           station
);
    logic [bas_pkg::SW_W-1:0]   sw_meta;
    logic [bas_pkg::SW_W-1:0]   sw_sync;
    logic [bas_pkg::ADDR_W-1:0] cfg_store;
    bas_pkg::bas_state_type     state;
    logic [bas_pkg::ADDR_W-1:0] sw_addr;
    logic                       sw_ok;

    // Switches are mechanical, so two flops before use
    // No reset: both stages fill while reset is held, so the setting
    // is through the synchroniser when sampling comes
    always_ff @(posedge mclk) begin
        sw_meta <= switch_on;
        sw_sync <= sw_meta;
    end

    // Stands in for the nonvolatile store; a real part keeps it in flash
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_store <= bas_pkg::CFG_RESET;
        end else if (cfg_we) begin
            cfg_store <= cfg_addr;
        end
    end

    assign sw_addr = sw_sync[bas_pkg::ADDR_W-1:0];
    assign sw_ok   = (sw_addr >= bas_pkg::ADDR_MIN) &&
                     (sw_addr <= bas_pkg::ADDR_MAX);

    // Extra cycle lets the synchroniser settle before sampling
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= bas_pkg::BAS_IDLE;
        end else begin
            case (state)
                bas_pkg::BAS_IDLE:   state <= bas_pkg::BAS_SAMPLE;
                bas_pkg::BAS_SAMPLE: state <= bas_pkg::BAS_RUN;
                bas_pkg::BAS_RUN:    state <= bas_pkg::BAS_RUN;
                default:             state <= bas_pkg::BAS_IDLE;
            endcase
        end
    end

    // Latched once; later switch changes wait for reset, which reloads the store with CFG_RESET
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            station <= '0;
        end else if (state == bas_pkg::BAS_SAMPLE) begin
            station.valid       <= 1'b1;
            station.from_switch <= sw_sync[bas_pkg::SRC_BIT];
            if (sw_sync[bas_pkg::SRC_BIT]) begin
                station.bad_switch <= !sw_ok;
                station.addr       <= sw_ok ? sw_addr : cfg_store;
            end else begin
                station.bad_switch <= 1'b0;
                station.addr       <= cfg_store;
            end
        end
    end

    sequence s_idle;
        state == bas_pkg::BAS_IDLE;
    endsequence

    sequence s_sample;
        state == bas_pkg::BAS_SAMPLE;
    endsequence

    sequence s_run;
        state == bas_pkg::BAS_RUN;
    endsequence

    // Three steps after reset, then the machine parks
    sequence s_boot_walk;
        s_idle ##1 s_sample ##1 s_run;
    endsequence

    sequence s_switch_ok;
        sw_sync[bas_pkg::SRC_BIT] && sw_ok;
    endsequence

    sequence s_switch_bad;
        sw_sync[bas_pkg::SRC_BIT] && !sw_ok;
    endsequence

    sequence s_soft;
        !sw_sync[bas_pkg::SRC_BIT];
    endsequence

    // Start-up order
    a_boot_order: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_idle |-> s_boot_walk)
        else $error("start-up order broken");

    a_sample_once: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample |=> s_run)
        else $error("source sampled more than once");

    a_run_stays: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_run |=> s_run)
        else $error("run state left without reset");

    a_idle_invalid: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_idle |-> !station.valid)
        else $error("address valid before sampling");

    a_run_valid: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_run |-> station.valid)
        else $error("address not valid after sampling");

    a_valid_time: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(state == bas_pkg::BAS_SAMPLE) |->
        !station.valid ##1 station.valid)
        else $error("address not latched on time");

    // Source choice and range
    a_src_flag: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample |=>
        station.from_switch == $past(sw_sync[bas_pkg::SRC_BIT]))
        else $error("source flag does not follow eighth position");

    a_switch_source: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and s_switch_ok |=> station.addr == $past(sw_addr))
        else $error("switch address not taken");

    a_soft_source: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and s_soft |=> station.addr == $past(cfg_store))
        else $error("configured address not taken");

    a_soft_clean: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and s_soft |=> !station.bad_switch)
        else $error("configured address flagged as bad switch");

    a_good_clean: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and s_switch_ok |=> !station.bad_switch)
        else $error("legal switch address flagged as bad");

    a_bad_fallback: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and s_switch_bad |=>
        station.bad_switch && station.addr == $past(cfg_store))
        else $error("bad switch address used");

    a_bad_only_switch: assert property (
        @(posedge mclk) disable iff (sys_rst)
        station.bad_switch |-> station.from_switch)
        else $error("bad flag without switch source");

    a_range_check: assert property (
        @(posedge mclk) disable iff (sys_rst)
        station.valid && station.from_switch && !station.bad_switch |->
        station.addr >= bas_pkg::ADDR_MIN &&
        station.addr <= bas_pkg::ADDR_MAX)
        else $error("switch address out of range");

    a_bit_order: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and (sw_sync == 8'h83) |=> station.addr == 7'h03)
        else $error("switch bit order wrong");

    a_on_is_one: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_sample and (sw_sync == 8'hFE) |=> station.addr == 7'h7E)
        else $error("switch polarity wrong");

    // Every address bit follows its own switch position
    for (genvar i = 0; i < bas_pkg::ADDR_W; i++) begin : g_bit_map
        a_bit_map: assert property (
            @(posedge mclk) disable iff (sys_rst)
            s_sample and s_switch_ok |=> station.addr[i] == $past(sw_sync[i]))
            else $error("switch position not mapped to its bit");
    end

    // Held until the next reset
    a_addr_held: assert property (
        @(posedge mclk) disable iff (sys_rst)
        station.valid |=> $stable(station))
        else $error("address changed without reset");

    a_late_switch: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_run and $changed(sw_sync) |=> $stable(station))
        else $error("late switch change reached the address");

    a_late_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s_run and cfg_we |=> $stable(station))
        else $error("late store write reached the address");

    // Configured-address store
    a_store_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        cfg_we |=> cfg_store == $past(cfg_addr))
        else $error("store write lost");

    a_store_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !cfg_we |=> $stable(cfg_store))
        else $error("store changed without a write");
endmodule : bas_select

//--- testbench/bas_master.sv
// Bus master model writing the configured address
module bas_master (
    input  wire logic                    mclk,
    output logic                         cfg_we,
    output logic [bas_pkg::ADDR_W-1:0]   cfg_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cfg_we   = 1'h0;
        cfg_addr = 7'h00;
    end
    // Call just after a rising edge
    task automatic put(input logic [bas_pkg::ADDR_W-1:0] a);
        cfg_we   = 1'h1;
        cfg_addr = a;
        @(posedge mclk);
        #1 cfg_we = 1'h0;
        cfg_addr = ~a; // Released lines must not keep old value
    endtask : put
endmodule : bas_master

//--- testbench/test_bas_select.sv
// Testbench for the station address source selector
module test_bas_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  mclk      = 1'h0;
    logic                  sys_rst   = 1'h1;
    logic [7:0]            switch_on = 8'h00;
    logic                  cfg_we;
    logic [6:0]            cfg_addr;
    bas_pkg::bas_addr_type station;
    int                    n_errors  = 0;
    int                    checks    = 0;
    int                    cyc       = 0;
    always #25 mclk = ~mclk;
    bas_master bm (.mclk(mclk), .cfg_we(cfg_we), .cfg_addr(cfg_addr));
    bas_select dut (.mclk(mclk), .sys_rst(sys_rst), .switch_on(switch_on),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .station(station));
    // Whole run needs well under 200 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input bas_pkg::bas_addr_type e);
        checks++;
        if (station !== e) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, e, station);
        end
    endtask : chk
    // Switch stable through reset; optional write before sampling
    task automatic boot(input logic [7:0] sw, input logic wr,
                        input logic [6:0] a, input bas_pkg::bas_addr_type e);
        sys_rst   = 1'h1;
        switch_on = sw;
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'h0;
        // Write lands at the first edge, before the sampling edge
        if (wr) bm.put(a);
        else @(posedge mclk);
        @(posedge mclk);
        #1 chk(e);
    endtask : boot
    task automatic t_switch_range();
        boot(8'h83, 1'h0, 7'h00, '{1'h1, 1'h1, 1'h0, 7'h03});
        boot(8'hFE, 1'h0, 7'h00, '{1'h1, 1'h1, 1'h0, 7'h7E});
    endtask : t_switch_range
    task automatic t_bit_map();
        boot(8'hA5, 1'h0, 7'h00, '{1'h1, 1'h1, 1'h0, 7'h25});
        boot(8'hCA, 1'h0, 7'h00, '{1'h1, 1'h1, 1'h0, 7'h4A});
    endtask : t_bit_map
    task automatic t_bad_switch();
        boot(8'h82, 1'h1, 7'h11, '{1'h1, 1'h1, 1'h1, 7'h11});
        boot(8'hFF, 1'h1, 7'h2C, '{1'h1, 1'h1, 1'h1, 7'h2C});
    endtask : t_bad_switch
    task automatic t_soft_source();
        boot(8'h05, 1'h1, 7'h40, '{1'h1, 1'h0, 1'h0, 7'h40});
    endtask : t_soft_source
    task automatic t_hold_until_reset();
        boot(8'h7F, 1'h0, 7'h00, '{1'h1, 1'h0, 1'h0, 7'h7E});
        switch_on = 8'h90;
        bm.put(7'h22);
        repeat (3) @(posedge mclk);
        #1 chk('{1'h1, 1'h0, 1'h0, 7'h7E});
        boot(8'h90, 1'h0, 7'h00, '{1'h1, 1'h1, 1'h0, 7'h10});
    endtask : t_hold_until_reset
    initial begin
        t_switch_range();
        t_bit_map();
        t_bad_switch();
        t_soft_source();
        t_hold_until_reset();
        end_sim();
    end
endmodule : test_bas_select
